// *** common/spimsp_pkg.sv ***
// Shared constants and types for the SPI master/slave port
package spimsp_pkg;
  localparam int BYTE_BITS = 8;
  localparam logic [3:0] LAST_EDGE = 4'hf;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // Control byte fields
  localparam int CTL_IE = 7;
  localparam int CTL_PE = 6;
  localparam int CTL_DIVEN = 5;
  localparam int CTL_MS = 4;
  localparam int CTL_POL = 3;
  localparam int CTL_PHA = 2;
  localparam int CTL_RATE_HI = 1;
  localparam int CTL_RATE_LO = 0;
  localparam logic [7:0] CTL_RST = 8'h00;
  // Control/status byte fields
  localparam int CSR_SSM = 1;
  localparam int CSR_SSI = 0;
  localparam logic CSR_SSM_RST = 1'b0;
  localparam logic CSR_SSI_RST = 1'b0;
  // Synchroniser lanes; select resets high
  localparam int SY_SCK = 0;
  localparam int SY_MOSI = 1;
  localparam int SY_MISO = 2;
  localparam int SY_SS = 3;
  localparam logic [3:0] SYNC_RST = 4'h8;
  // Master serial clock half periods in core cycles
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  typedef enum logic [1:0] {ST_IDLE = 2'b01, ST_SHIFT = 2'b10} spimsp_state_type;
endpackage : spimsp_pkg

// *** common/spimsp_stream_if.sv ***
// Valid/ready byte stream between shifter, buffer and receive register
`timescale 1ns/1ps
interface spimsp_stream_if;
  import spimsp_pkg::*;
  logic valid;
  logic ready;
  logic [BYTE_BITS-1:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface : spimsp_stream_if

// *** design/spimsp_clkgen.sv ***
// Master serial clock edge generator
`timescale 1ns/1ps
module spimsp_clkgen
  import spimsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic run,
  input wire logic [2:0] rate,
  output logic edge_pulse
);
  logic [6:0] cnt_r;
  logic [6:0] half;

  function automatic logic [6:0] half_of(input logic [2:0] r);
    case (r)
      3'b100: half_of = HALF_DIV4;
      3'b000: half_of = HALF_DIV8;
      3'b001: half_of = HALF_DIV16;
      3'b110: half_of = HALF_DIV32;
      3'b010: half_of = HALF_DIV64;
      3'b011: half_of = HALF_DIV128;
      // Unlisted codes fall back to a safe rate
      default: half_of = HALF_DIV8;
    endcase
  endfunction : half_of

  assign half = half_of(rate);

  always_ff @(posedge core_clk) begin
    if (srst || !run) begin
      cnt_r <= 7'h00;
      edge_pulse <= 1'b0;
    end else if (cnt_r == half - 7'h01) begin
      cnt_r <= 7'h00;
      edge_pulse <= 1'b1;
    end else begin
      cnt_r <= cnt_r + 7'h01;
      edge_pulse <= 1'b0;
    end
  end

  chk_edge_gap: assert property (@(posedge core_clk) disable iff (srst)
    (edge_pulse && run && rate == 3'b100) |=> !edge_pulse)
    else $error("serial clock edges closer than a half period");
endmodule : spimsp_clkgen

// *** design/spimsp_rxbuf.sv ***
// Two-entry receive buffer between the shifter and the receive register
`timescale 1ns/1ps
module spimsp_rxbuf
  import spimsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  spimsp_stream_if.snk fill,
  spimsp_stream_if.src drain
);
  logic [BYTE_BITS-1:0] mem_r [2];
  logic wp_r;
  logic rp_r;
  logic [1:0] cnt_r;
  logic push;
  logic pop;

  assign fill.ready = (cnt_r != 2'h2);
  assign drain.valid = (cnt_r != 2'h0);
  assign drain.data = mem_r[rp_r];
  assign push = fill.valid & fill.ready;
  assign pop = drain.valid & drain.ready;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) begin
        wp_r <= ~wp_r;
      end
      if (pop) begin
        rp_r <= ~rp_r;
      end
      case ({push, pop})
        2'b10: cnt_r <= cnt_r + 2'h1;
        2'b01: cnt_r <= cnt_r - 2'h1;
        default: cnt_r <= cnt_r;
      endcase
    end
  end

  // Storage needs no reset; count guards it
  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_r[wp_r] <= fill.data;
    end
  end

  chk_buf_full: assert property (@(posedge core_clk) disable iff (srst)
    (cnt_r == 2'h2 && !pop) |=> (cnt_r == 2'h2 && !fill.ready))
    else $error("full buffer accepted or lost a byte");
endmodule : spimsp_rxbuf

// *** design/spimsp_top.sv ***
// SPI master/slave port: shifter, flags, select logic and pin drive
//
// What this block does
// - Software select mode ignores the select pin and uses the soft level bit.
// - First-edge slave with select held low gets a collision on data write.
// - Master drives serial clock with rate, polarity and phase from settings.
// - In master mode, master select and port enable stay set only while select is high.
// - Master data write loads shifter and starts MSB-first shift-out.
// - Slave data write loads shifter; shifting waits for master clock edges.
// - Byte end sets done flag; interrupt when enabled and CPU mask clear.
// - Done clears by status access then data read, or slave write.
// - Data writes ignored while done set until status register read.
// - Polarity sets idle level; with phase chooses capture edge.
// - Master with select low sets fault, drops enable and master select.
// - Fault clears by status read while set, then control write.
// - While fault set, enable and master select cannot be set except clearing.
// - Byte completing with done set raises overrun; first byte kept.
// - Overrun clears on status register read.
// - Data write during transfer is discarded and sets collision flag.
// - Collision never interrupts; received data buffered, reads never collide.
// - Rate bits select one of six divisions from quarter to 1/128.
// - Port enable clear releases pins; set lets the port drive them.
// - Interrupt enable gates one request from done, fault or overrun.
`timescale 1ns/1ps
module spimsp_top
  import spimsp_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic ctl_wr,
  input wire logic [7:0] ctl_wdata,
  input wire logic csr_rd,
  input wire logic csr_wr,
  input wire logic [7:0] csr_wdata,
  input wire logic dr_rd,
  input wire logic dr_wr,
  input wire logic [7:0] dr_wdata,
  input wire logic cpu_irq_mask,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic ss_n_in,
  output logic [7:0] rx_data,
  output logic transfer_done_flag,
  output logic write_collision_flag,
  output logic overrun_flag,
  output logic mode_fault_flag,
  output logic port_enable,
  output logic master_select,
  output logic irq_req
);
  spimsp_state_type st_r;
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic sck_prev_r;
  logic ie_r, pe_r, ms_r, pol_r, pha_r, diven_r;
  logic [1:0] rate_r;
  logic ssm_r, ssi_r;
  logic [7:0] sh_r;
  logic mo_r, sck_r;
  logic [3:0] edge_cnt_r;
  logic [2:0] cap_cnt_r;
  logic pend_r;
  logic [7:0] pend_byte_r;
  logic [7:0] rx_r;
  logic tdf_r, transfer_done_flag_arm_r, transfer_done_flag_rd_r;
  logic ovr_r, write_collision_flag_r, write_collision_flag_arm_r, mode_fault_flag_r, mode_fault_flag_arm_r;
  logic irq_r, sck_oe_n_r, mosi_oe_n_r, miso_oe_n_r;
  logic ss_int, in_bit, slave_sel, medge, edge_ev, lead, cap, launch;
  logic active, busy, wr_blocked, dr_take, write_collision_flag_set, fault, ctl_lock;
  logic rx_take, tdf_clr, byte_end;
  logic cap_dly_r;

  spimsp_stream_if push_if ();
  spimsp_stream_if pop_if ();

  // Pins cross into the core clock through two flops
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sync1_r <= SYNC_RST;
      sync2_r <= SYNC_RST;
      sck_prev_r <= 1'b0;
    end else begin
      sync1_r <= {ss_n_in, miso_in, mosi_in, sck_in};
      sync2_r <= sync1_r;
      sck_prev_r <= sync2_r[SY_SCK];
    end
  end

  assign ss_int = ssm_r ? ssi_r : sync2_r[SY_SS];
  assign in_bit = ms_r ? sync2_r[SY_MISO] : sync2_r[SY_MOSI];
  assign slave_sel = pe_r & !ms_r & !ss_int;
  assign edge_ev = ms_r ? medge : ((sync2_r[SY_SCK] ^ sck_prev_r) & slave_sel);
  // Leading edge leaves the idle level
  assign lead = ms_r ? (sck_r == pol_r) : (sck_prev_r == pol_r);
  assign cap = ms_r ? cap_dly_r : (edge_ev & (lead ^ pha_r));
  assign launch = edge_ev & !(lead ^ pha_r);
  assign active = ms_r ? (st_r == ST_SHIFT) : slave_sel;
  // First-edge slave stays busy while selected
  assign busy = ms_r ? (st_r == ST_SHIFT)
              : ((edge_cnt_r != 4'h0) | (!pha_r & slave_sel));
  assign wr_blocked = tdf_r & !transfer_done_flag_rd_r;
  assign dr_take = dr_wr & !wr_blocked & !busy;
  assign write_collision_flag_set = dr_wr & !wr_blocked & busy;
  assign fault = ms_r & !ss_int;
  assign ctl_lock = mode_fault_flag_r & !mode_fault_flag_arm_r;
  assign byte_end = cap & (cap_cnt_r == LAST_BIT);
  assign rx_take = pop_if.valid & pop_if.ready;
  // Master must read; slave may read or write
  assign tdf_clr = tdf_r & transfer_done_flag_arm_r & (dr_rd | (!ms_r & dr_wr));

  spimsp_clkgen u_clkgen (
    .core_clk(core_clk),
    .srst(srst),
    .run(ms_r & (st_r == ST_SHIFT)),
    .rate({diven_r, rate_r}),
    .edge_pulse(medge)
  );

  spimsp_rxbuf u_rxbuf (
    .core_clk(core_clk),
    .srst(srst),
    .fill(push_if.snk),
    .drain(pop_if.src)
  );

  assign push_if.valid = pend_r;
  assign push_if.data = pend_byte_r;
  // Drain stalls during a data read so the read sees a steady byte
  assign pop_if.ready = !dr_rd;

  // Control register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ie_r <= CTL_RST[CTL_IE];
      diven_r <= CTL_RST[CTL_DIVEN];
      pol_r <= CTL_RST[CTL_POL];
      pha_r <= CTL_RST[CTL_PHA];
      rate_r <= CTL_RST[CTL_RATE_HI:CTL_RATE_LO];
    end else if (ctl_wr) begin
      ie_r <= ctl_wdata[CTL_IE];
      diven_r <= ctl_wdata[CTL_DIVEN];
      pol_r <= ctl_wdata[CTL_POL];
      pha_r <= ctl_wdata[CTL_PHA];
      rate_r <= ctl_wdata[CTL_RATE_HI:CTL_RATE_LO];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pe_r <= CTL_RST[CTL_PE];
      ms_r <= CTL_RST[CTL_MS];
    end else if (fault) begin
      pe_r <= 1'b0;
      ms_r <= 1'b0;
    end else if (ctl_wr) begin
      pe_r <= ctl_wdata[CTL_PE] & (pe_r | !ctl_lock);
      ms_r <= ctl_wdata[CTL_MS] & (ms_r | !ctl_lock);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ssm_r <= CSR_SSM_RST;
      ssi_r <= CSR_SSI_RST;
    end else if (csr_wr) begin
      ssm_r <= csr_wdata[CSR_SSM];
      ssi_r <= csr_wdata[CSR_SSI];
    end
  end

  // Transfer sequencing for master mode
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st_r <= ST_IDLE;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (dr_take && ms_r && pe_r) begin
            st_r <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (!ms_r || !pe_r || (medge && edge_cnt_r == LAST_EDGE)) begin
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Master capture one cycle late: the synchronised input lags the pin by two
  always_ff @(posedge core_clk) begin
    if (srst) begin
      cap_dly_r <= 1'b0;
    end else begin
      cap_dly_r <= ms_r & medge & (lead ^ pha_r);
    end
  end

  // Sixteen edges and eight captures per byte
  always_ff @(posedge core_clk) begin
    if (srst || !active) begin
      edge_cnt_r <= 4'h0;
      cap_cnt_r <= 3'h0;
    end else begin
      if (edge_ev) begin
        edge_cnt_r <= edge_cnt_r + 4'h1;
      end
      if (cap) begin
        cap_cnt_r <= cap_cnt_r + 3'h1;
      end
    end
  end

  // Slave shifts only on master edges
  always_ff @(posedge core_clk) begin
    if (srst) begin
      sh_r <= 8'h00;
      mo_r <= 1'b0;
    end else if (dr_take) begin
      sh_r <= dr_wdata;
      mo_r <= dr_wdata[7];
    end else if (cap) begin
      sh_r <= {sh_r[6:0], in_bit};
    end else if (launch) begin
      mo_r <= sh_r[7];
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || !(ms_r && st_r == ST_SHIFT)) begin
      sck_r <= pol_r;
    end else if (medge) begin
      sck_r <= ~sck_r;
    end
  end

  // Completed byte waits here while the buffer is full
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pend_r <= 1'b0;
      pend_byte_r <= 8'h00;
    end else if (byte_end) begin
      pend_r <= 1'b1;
      pend_byte_r <= {sh_r[6:0], in_bit};
    end else if (push_if.ready) begin
      pend_r <= 1'b0;
    end
  end

  // Only the first byte after the flag cleared is kept
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rx_r <= 8'h00;
    end else if (rx_take && (!tdf_r || tdf_clr)) begin
      rx_r <= pop_if.data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      tdf_r <= 1'b0;
    end else if (rx_take) begin
      tdf_r <= 1'b1;
    end else if (tdf_clr) begin
      tdf_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || !tdf_r || tdf_clr) begin
      transfer_done_flag_arm_r <= 1'b0;
      transfer_done_flag_rd_r <= 1'b0;
    end else begin
      if (csr_rd || csr_wr) begin
        transfer_done_flag_arm_r <= 1'b1;
      end
      if (csr_rd) begin
        transfer_done_flag_rd_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ovr_r <= 1'b0;
    end else if (rx_take && tdf_r && !tdf_clr) begin
      ovr_r <= 1'b1;
    end else if (csr_rd) begin
      ovr_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      write_collision_flag_r <= 1'b0;
      write_collision_flag_arm_r <= 1'b0;
    end else if (write_collision_flag_set) begin
      write_collision_flag_r <= 1'b1;
      write_collision_flag_arm_r <= 1'b0;
    end else if (write_collision_flag_arm_r && (dr_rd || dr_wr)) begin
      write_collision_flag_r <= 1'b0;
      write_collision_flag_arm_r <= 1'b0;
    end else if (csr_rd && write_collision_flag_r) begin
      write_collision_flag_arm_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      mode_fault_flag_r <= 1'b0;
    end else if (fault) begin
      mode_fault_flag_r <= 1'b1;
    end else if (ctl_wr && mode_fault_flag_arm_r) begin
      mode_fault_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst || !mode_fault_flag_r) begin
      mode_fault_flag_arm_r <= 1'b0;
    end else if (csr_rd) begin
      mode_fault_flag_arm_r <= 1'b1;
    end
  end

  // Collision is status only and never interrupts
  always_ff @(posedge core_clk) begin
    if (srst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ie_r & !cpu_irq_mask & (tdf_r | mode_fault_flag_r | ovr_r);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sck_oe_n_r <= 1'b1;
      mosi_oe_n_r <= 1'b1;
      miso_oe_n_r <= 1'b1;
    end else begin
      sck_oe_n_r <= !(pe_r & ms_r);
      mosi_oe_n_r <= !(pe_r & ms_r);
      miso_oe_n_r <= !slave_sel;
    end
  end

  assign sck_out = sck_r;
  assign sck_oe_n = sck_oe_n_r;
  assign mosi_out = mo_r;
  assign mosi_oe_n = mosi_oe_n_r;
  assign miso_out = mo_r;
  assign miso_oe_n = miso_oe_n_r;
  assign rx_data = rx_r;
  assign transfer_done_flag = tdf_r;
  assign write_collision_flag = write_collision_flag_r;
  assign overrun_flag = ovr_r;
  assign mode_fault_flag = mode_fault_flag_r;
  assign port_enable = pe_r;
  assign master_select = ms_r;
  assign irq_req = irq_r;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  chk_soft_select: assert property (
    (ssm_r && ssi_r && ms_r && !mode_fault_flag_r && $fell(sync2_r[SY_SS])) |=> !mode_fault_flag_r)
    else $error("select pin reached logic in software select mode");
  chk_fault_drop: assert property (
    (ms_r && !ss_int) |=> (mode_fault_flag_r && !pe_r && !ms_r))
    else $error("mode fault did not drop enable and master select");
  chk_fault_lock: assert property (
    (ctl_lock && !pe_r && ctl_wr) |=> !pe_r)
    else $error("port enable set while fault locked");
  chk_done_irq: assert property (
    (tdf_r && ie_r && !cpu_irq_mask) |=> irq_r)
    else $error("done flag did not raise interrupt");
  chk_write_collision_flag_quiet: assert property (
    (write_collision_flag_r && !tdf_r && !mode_fault_flag_r && !ovr_r) |=> !irq_r)
    else $error("collision raised an interrupt");
  chk_write_ignored: assert property (
    (dr_wr && wr_blocked && ms_r && st_r == ST_IDLE) |=> st_r == ST_IDLE)
    else $error("blocked data write started a transfer");
  chk_collide_set: assert property (
    (dr_wr && busy && !wr_blocked) |=> (write_collision_flag_r && $stable(st_r)))
    else $error("collision not flagged");
  chk_byte_len: assert property (
    (ms_r && st_r == ST_SHIFT && medge && edge_cnt_r == LAST_EDGE)
      |-> cap_cnt_r == (pha_r ? LAST_BIT : 3'h0))
    else $error("byte did not take eight capture edges");
  chk_ovr_clear: assert property (
    (csr_rd && !(rx_take && tdf_r && !tdf_clr)) |=> !ovr_r)
    else $error("overrun survived a status read");
  chk_sck_idle: assert property (
    (st_r == ST_IDLE) |=> sck_r == $past(pol_r))
    else $error("serial clock not at idle level");
  chk_pins_free: assert property (
    !pe_r |=> (sck_oe_n_r && mosi_oe_n_r && miso_oe_n_r))
    else $error("pins driven with port disabled");
endmodule : spimsp_top

// *** bench/spimsp_slave_model.sv ***
// Behavioural SPI slave that faces the port while it runs as master
`timescale 1ns/1ps
module spimsp_slave_model (
  input wire logic sel_n,
  input wire logic sck,
  input wire logic mosi,
  input wire logic pol,
  input wire logic pha,
  input wire logic [7:0] tx_byte,
  output logic miso,
  output logic [7:0] rx_byte,
  output int n_bytes
);
  logic [7:0] sh_r;
  int nbit;
  int nout;
  initial begin
    miso = 1'b0;
    rx_byte = 8'h00;
    n_bytes = 0;
  end
  // Released line shows the inverse of its last bit, never a held value
  always @(posedge sel_n) begin
    miso = ~miso;
  end
  always @(negedge sel_n) begin
    nbit = 0;
    nout = 0;
    if (!pha) begin
      miso = tx_byte[7];
      nout = 1;
    end
  end
  // Edges only count while selected, so pull level changes are ignored
  always @(sck) begin
    if (!sel_n) begin
      if ((sck ^ pol) != pha) begin
        sh_r = {sh_r[6:0], mosi};
        nbit++;
        if (nbit == 8) begin
          rx_byte = sh_r;
          n_bytes++;
        end
      end else if (nout < 8) begin
        miso = tx_byte[7 - nout];
        nout++;
      end
    end
  end
endmodule : spimsp_slave_model

// *** bench/spimsp_top_bench.sv ***
// Self-checking bench for the SPI port running as master
`timescale 1ns/1ps
module spimsp_top_bench;
  import spimsp_pkg::*;
  localparam int K_CTL = 0;
  localparam int K_CSRRD = 1;
  localparam int K_CSRWR = 2;
  localparam int K_DRRD = 3;
  localparam int K_DRWR = 4;
  localparam logic [2:0] RATES [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  localparam logic [6:0] HALVES [6] = '{HALF_DIV4, HALF_DIV8, HALF_DIV16, HALF_DIV32,
    HALF_DIV64, HALF_DIV128};
  logic core_clk, srst, ctl_wr, csr_rd, csr_wr, dr_rd, dr_wr, cpu_irq_mask, ss_n_in;
  logic [7:0] wdata, rd_byte, mdl_tx, mdl_rx, rx_data;
  logic mdl_sel_n, mdl_pol, mdl_pha, mdl_miso, sck_line, mosi_line;
  logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_oe_n;
  logic transfer_done_flag, write_collision_flag, overrun_flag, mode_fault_flag;
  logic port_enable, master_select, irq_req;
  int mdl_n, fails, n_checks, cycles;
  // Pulls hold the idle levels once the port lets go of the pins
  assign sck_line = sck_oe_n ? mdl_pol : sck_out;
  assign mosi_line = mosi_oe_n ? 1'b1 : mosi_out;
  spimsp_top dut (.core_clk(core_clk), .srst(srst), .ctl_wr(ctl_wr), .ctl_wdata(wdata),
    .csr_rd(csr_rd), .csr_wr(csr_wr), .csr_wdata(wdata), .dr_rd(dr_rd), .dr_wr(dr_wr),
    .dr_wdata(wdata), .cpu_irq_mask(cpu_irq_mask), .sck_in(sck_line), .sck_out(sck_out),
    .sck_oe_n(sck_oe_n), .mosi_in(mosi_line), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .miso_in(mdl_miso), .miso_out(), .miso_oe_n(miso_oe_n), .ss_n_in(ss_n_in),
    .rx_data(rx_data), .transfer_done_flag(transfer_done_flag),
    .write_collision_flag(write_collision_flag), .overrun_flag(overrun_flag),
    .mode_fault_flag(mode_fault_flag), .port_enable(port_enable),
    .master_select(master_select), .irq_req(irq_req));
  spimsp_slave_model mdl (.sel_n(mdl_sel_n), .sck(sck_line), .mosi(mosi_line), .pol(mdl_pol),
    .pha(mdl_pha), .tx_byte(mdl_tx), .miso(mdl_miso), .rx_byte(mdl_rx), .n_bytes(mdl_n));
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 60000) begin
      fails++;
      finish_test();
    end
  end
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check8
  task automatic idle(input int n);
    repeat (n) @(negedge core_clk);
  endtask : idle
  // One strobe cycle; read data is taken while the strobe is high
  task automatic acc(input int k, input logic [7:0] v);
    @(negedge core_clk);
    wdata = v;
    {ctl_wr, csr_rd, csr_wr, dr_rd, dr_wr} = 5'h10 >> k;
    rd_byte = rx_data;
    @(negedge core_clk);
    {ctl_wr, csr_rd, csr_wr, dr_rd, dr_wr} = 5'h00;
  endtask : acc
  task automatic start_byte(input logic [7:0] tx, input logic [7:0] d);
    @(negedge core_clk);
    mdl_tx = tx;
    mdl_sel_n = 1'b0;
    acc(K_DRWR, d);
  endtask : start_byte
  task automatic wait_bytes(input int n);
    int i;
    for (i = 0; i < 3000 && mdl_n < n; i++) @(negedge core_clk);
    idle(8);
    mdl_sel_n = 1'b1;
  endtask : wait_bytes
  task automatic t_reset();
    check8({transfer_done_flag, write_collision_flag, overrun_flag, mode_fault_flag,
      port_enable, master_select, irq_req, 1'b0}, 8'h00);
    check8(rx_data, 8'h00);
    check8({5'h00, sck_oe_n, mosi_oe_n, miso_oe_n}, 8'h07);
  endtask : t_reset
  task automatic t_modes();
    logic [7:0] ctl;
    int i, n;
    for (i = 0; i < 6; i++) begin
      ctl = {2'b00, RATES[i][2], 1'b0, i[1], i[0], RATES[i][1:0]};
      mdl_pol = i[1];
      mdl_pha = i[0];
      acc(K_CTL, ctl);
      acc(K_CSRWR, 8'h03);
      acc(K_CTL, ctl | 8'h50);
      idle(2);
      check8(8'(port_enable), 8'h01);
      check8(8'(sck_line), 8'(mdl_pol));
      check8(8'(mosi_oe_n), 8'h00);
      start_byte(8'h3c + 8'(i), 8'hc5 - 8'(i));
      for (n = 0; n < 300 && sck_line === mdl_pol; n++) @(negedge core_clk);
      for (n = 0; n < 300 && sck_line !== mdl_pol; n++) @(negedge core_clk);
      check8(8'(n), {1'b0, HALVES[i]});
      wait_bytes(i + 1);
      check8(mdl_rx, 8'hc5 - 8'(i));
      check8(8'(transfer_done_flag), 8'h01);
      acc(K_CSRRD, 8'h00);
      acc(K_DRRD, 8'h00);
      check8(rd_byte, 8'h3c + 8'(i));
      idle(2);
      check8(8'(transfer_done_flag), 8'h00);
      // Port goes off before the next polarity is chosen
      acc(K_CTL, 8'h00);
      idle(2);
      check8(8'(sck_oe_n), 8'h01);
    end
  endtask : t_modes
  task automatic t_irq();
    mdl_pol = 1'b0;
    mdl_pha = 1'b0;
    acc(K_CTL, 8'h80);
    acc(K_CTL, 8'hd0);
    // Pin falls while soft select holds the master level high
    ss_n_in = 1'b1;
    idle(4);
    ss_n_in = 1'b0;
    idle(4);
    check8(8'(mode_fault_flag), 8'h00);
    start_byte(8'h5a, 8'h96);
    acc(K_DRWR, 8'h69);
    idle(2);
    check8(8'(write_collision_flag), 8'h01);
    check8(8'(irq_req), 8'h00);
    wait_bytes(7);
    check8(mdl_rx, 8'h96);
    check8(8'(irq_req), 8'h01);
    cpu_irq_mask = 1'b1;
    idle(2);
    check8(8'(irq_req), 8'h00);
    cpu_irq_mask = 1'b0;
    start_byte(8'ha1, 8'h11);
    idle(40);
    check8(8'(mdl_n), 8'h07);
    mdl_sel_n = 1'b1;
    acc(K_CSRRD, 8'h00);
    start_byte(8'h77, 8'h22);
    wait_bytes(8);
    check8(mdl_rx, 8'h22);
    check8(8'(overrun_flag), 8'h01);
    check8(rx_data, 8'h5a);
    acc(K_CSRRD, 8'h00);
    idle(2);
    check8(8'(overrun_flag), 8'h00);
    acc(K_DRRD, 8'h00);
    check8(rd_byte, 8'h5a);
  endtask : t_irq
  task automatic t_fault();
    // Pin mode with the pin held low: a select fault for a master
    acc(K_CSRWR, 8'h00);
    idle(2);
    check8({6'h00, port_enable, master_select}, 8'h00);
    check8(8'(mode_fault_flag), 8'h01);
    check8(8'(irq_req), 8'h01);
    acc(K_CSRWR, 8'h03);
    acc(K_CTL, 8'hd0);
    idle(2);
    check8({6'h00, port_enable, master_select}, 8'h00);
    acc(K_CSRRD, 8'h00);
    acc(K_CTL, 8'hd0);
    idle(2);
    check8(8'(mode_fault_flag), 8'h00);
    check8({6'h00, port_enable, master_select}, 8'h03);
  endtask : t_fault
  task automatic finish_test();
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test
  initial begin
    {ctl_wr, csr_rd, csr_wr, dr_rd, dr_wr} = 5'h00;
    srst = 1'b1;
    wdata = 8'h00;
    cpu_irq_mask = 1'b0;
    ss_n_in = 1'b0;
    mdl_sel_n = 1'b1;
    mdl_pol = 1'b0;
    mdl_pha = 1'b0;
    mdl_tx = 8'h00;
    fails = 0;
    n_checks = 0;
    cycles = 0;
    repeat (5) @(negedge core_clk);
    srst = 1'b0;
    t_reset();
    t_modes();
    t_irq();
    t_fault();
    finish_test();
  end
endmodule : spimsp_top_bench
